// ==== rtl/exec_pkg.sv ====
// shared constants, opcodes and state codes for the load/store execution block
package exec_pkg;

    localparam int REG_AW = 5;
    localparam int DW     = 8;
    localparam int AW     = 16;

    // decoded instruction codes presented on the request port
    typedef enum logic [3:0] {
        OP_NOP              = 4'h0,
        OP_LOAD_DIRECT      = 4'h1,
        OP_STORE_DIRECT     = 4'h2,
        OP_PTR_WRITE        = 4'h3,
        OP_PTR_WRITE_INC    = 4'h4,
        OP_PTR_WRITE_DEC    = 4'h5,
        OP_OFFSET_WRITE     = 4'h6,
        OP_CODE_READ_LOW    = 4'h7,
        OP_CODE_READ        = 4'h8,
        OP_CODE_READ_INC    = 4'h9,
        OP_POP              = 4'hA,
        OP_SLEEP            = 4'hB,
        OP_WATCHDOG_RESTART = 4'hC,
        OP_BREAK            = 4'hD
    } op_type;

    // first, second and third pointer
    typedef enum logic [1:0] {
        PTR_FIRST  = 2'h0,
        PTR_SECOND = 2'h1,
        PTR_THIRD  = 2'h2
    } ptr_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } state_type;

    // cycles each instruction class occupies
    localparam logic [1:0] CYC_DIRECT = 2'h2;
    localparam logic [1:0] CYC_PTR    = 2'h2;
    localparam logic [1:0] CYC_POP    = 2'h2;
    localparam logic [1:0] CYC_CODE   = 2'h3;
    localparam logic [1:0] CYC_CTRL   = 2'h1;

    localparam logic [REG_AW-1:0] LOW_RESULT_REG_ADDR = 5'h00;
    localparam logic [AW-1:0]     PTR_RESET           = 16'h0000;
    localparam logic [AW-1:0]     SP_RESET            = 16'h0000;
    localparam logic [AW-1:0]     PTR_STEP            = 16'h0001;

endpackage : exec_pkg

// ==== rtl/reg_file_if.sv ====
// carrier between the executor and its working-register memory
`timescale 1ns/1ns
`default_nettype none
interface reg_file_if;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic       we;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] dbg_addr;
    logic [7:0] dbg_data;
    modport core (output rd_addr, we, wr_addr, wr_data, dbg_addr, input rd_data, dbg_data);
    modport mem  (input rd_addr, we, wr_addr, wr_data, dbg_addr, output rd_data, dbg_data);
endinterface : reg_file_if
`default_nettype wire

// ==== rtl/reg_file_mem.sv ====
// working-register memory with registered read ports
`timescale 1ns/1ns
`default_nettype none
module reg_file_mem
    import exec_pkg::*;
#(
    parameter int DEPTH = 32
) (
    input  wire logic   mclk_i,
    input  wire logic   rstn_i,
    reg_file_if.mem     rf
);
    logic [DW-1:0] mem_r [DEPTH];
    logic [DW-1:0] rd_r;
    logic [DW-1:0] dbg_r;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            logic [DW-1:0] ent_nxt;
            always_comb begin
                ent_nxt = mem_r[gi];
                if (rf.we && (rf.wr_addr == REG_AW'(gi))) begin
                    ent_nxt = rf.wr_data;
                end
            end
            always_ff @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    mem_r[gi] <= 8'h00;
                end else begin
                    mem_r[gi] <= ent_nxt;
                end
            end
        end
    endgenerate

    // reads see the contents before a same-edge write
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_r  <= 8'h00;
            dbg_r <= 8'h00;
        end else begin
            rd_r  <= mem_r[rf.rd_addr];
            dbg_r <= mem_r[rf.dbg_addr];
        end
    end

    assign rf.rd_data  = rd_r;
    assign rf.dbg_data = dbg_r;
endmodule : reg_file_mem
`default_nettype wire

// ==== rtl/load_store_exec.sv ====
// execution of the load, store, code-read, pop and core-control instructions
`timescale 1ns/1ns
`default_nettype none
module load_store_exec
    import exec_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic              insn_valid_i,
    input  wire op_type            insn_op_i,
    input  wire logic [REG_AW-1:0] insn_reg_i,
    input  wire ptr_type           insn_ptr_i,
    input  wire logic [AW-1:0]     insn_imm_i,
    output logic                   ready_o,
    output logic                   done_o,
    output logic [AW-1:0]          dmem_addr_o,
    output logic [DW-1:0]          dmem_wdata_o,
    output logic                   dmem_we_o,
    output logic                   dmem_re_o,
    input  wire logic [DW-1:0]     dmem_rdata_i,
    output logic [AW-1:0]          pmem_addr_o,
    output logic                   pmem_re_o,
    input  wire logic [DW-1:0]     pmem_rdata_i,
    output logic                   sleep_o,
    output logic                   watchdog_restart_o,
    output logic                   break_o,
    input  wire logic              ptr_load_i,
    input  wire ptr_type           ptr_load_sel_i,
    input  wire logic [AW-1:0]     ptr_load_data_i,
    input  wire logic              sp_load_i,
    input  wire logic [AW-1:0]     sp_load_data_i,
    input  wire logic              rf_load_i,
    input  wire logic [REG_AW-1:0] rf_load_addr_i,
    input  wire logic [DW-1:0]     rf_load_data_i,
    input  wire logic [REG_AW-1:0] dbg_reg_addr_i,
    output logic [DW-1:0]          dbg_reg_data_o,
    output logic [AW-1:0]          ptr_first_o,
    output logic [AW-1:0]          ptr_second_o,
    output logic [AW-1:0]          ptr_third_o,
    output logic [AW-1:0]          sp_o
);
    reg_file_if rf ();
    reg_file_mem #(.DEPTH(32)) u_regs (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .rf     (rf.mem)
    );
    state_type         state_r,   state_nxt;
    logic [1:0]        cnt_r,     cnt_nxt;
    logic              first_r,   first_nxt;
    op_type            op_r,      op_nxt;
    logic [REG_AW-1:0] reg_r,     reg_nxt;
    ptr_type           sel_r,     sel_nxt;
    logic [AW-1:0]     imm_r,     imm_nxt;
    logic [AW-1:0]     px_r,      px_nxt;
    logic [AW-1:0]     py_r,      py_nxt;
    logic [AW-1:0]     pz_r,      pz_nxt;
    logic [AW-1:0]     sp_r,      sp_nxt;
    logic [AW-1:0]     daddr_r,   daddr_nxt;
    logic [DW-1:0]     wdata_r,   wdata_nxt;
    logic              dwe_r,     dwe_nxt;
    logic              dre_r,     dre_nxt;
    logic [AW-1:0]     paddr_r,   paddr_nxt;
    logic              pre_r,     pre_nxt;
    logic              ready_r,   ready_nxt;
    logic              done_r,    done_nxt;
    logic              sleep_r,   sleep_nxt;
    logic              wdt_r,     wdt_nxt;
    logic              brk_r,     brk_nxt;
    logic              wb_low_r,  wb_low_nxt;
    logic              accept;
    logic [AW-1:0]     ptr_cur;
    logic [AW-1:0]     ptr_new;
    logic              ptr_upd;
    assign accept = insn_valid_i && ready_r;
    function automatic logic [1:0] cycles_of(input op_type op);
        case (op)
            OP_LOAD_DIRECT, OP_STORE_DIRECT:     cycles_of = CYC_DIRECT;
            OP_PTR_WRITE, OP_PTR_WRITE_INC, OP_PTR_WRITE_DEC, OP_OFFSET_WRITE: cycles_of = CYC_PTR;
            OP_CODE_READ_LOW, OP_CODE_READ, OP_CODE_READ_INC: cycles_of = CYC_CODE;
            OP_POP:                              cycles_of = CYC_POP;
            default:                             cycles_of = CYC_CTRL;
        endcase
    endfunction : cycles_of
    // selected pointer; the offset form never uses the first pointer
    always_comb begin
        case (sel_r)
            PTR_FIRST: ptr_cur = (op_r == OP_OFFSET_WRITE) ? py_r : px_r;
            PTR_THIRD: ptr_cur = pz_r;
            default:   ptr_cur = py_r;
        endcase
    end
    // register-file ports: source read follows the request, write-back uses the read data
    always_comb begin
        rf.rd_addr  = (state_r == ST_IDLE) ? insn_reg_i : reg_r;
        rf.dbg_addr = dbg_reg_addr_i;
        rf.we       = dre_r || pre_r || (rf_load_i && ready_r);
        rf.wr_addr  = reg_r;
        rf.wr_data  = rf_load_data_i;
        if (dre_r) begin
            rf.wr_data = dmem_rdata_i;
        end else if (pre_r) begin
            rf.wr_data = pmem_rdata_i;
            rf.wr_addr = wb_low_r ? LOW_RESULT_REG_ADDR : reg_r;
        end else begin
            rf.wr_addr = rf_load_addr_i;
        end
    end
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        first_nxt  = 1'b0;
        op_nxt     = op_r;
        reg_nxt    = reg_r;
        sel_nxt    = sel_r;
        imm_nxt    = imm_r;
        px_nxt     = px_r;
        py_nxt     = py_r;
        pz_nxt     = pz_r;
        sp_nxt     = sp_r;
        daddr_nxt  = daddr_r;
        wdata_nxt  = wdata_r;
        paddr_nxt  = paddr_r;
        wb_low_nxt = wb_low_r;
        dwe_nxt    = 1'b0;
        dre_nxt    = 1'b0;
        pre_nxt    = 1'b0;
        done_nxt   = 1'b0;
        sleep_nxt  = 1'b0;
        wdt_nxt    = 1'b0;
        brk_nxt    = 1'b0;
        ptr_new    = ptr_cur;
        ptr_upd    = 1'b0;
        // no path here reaches a status flag: every instruction of this block leaves them alone
        case (state_r)
            ST_IDLE: begin
                if (ptr_load_i) case (ptr_load_sel_i)
                    PTR_FIRST: px_nxt = ptr_load_data_i;
                    PTR_THIRD: pz_nxt = ptr_load_data_i;
                    default:   py_nxt = ptr_load_data_i;
                endcase
                if (sp_load_i) sp_nxt = sp_load_data_i;
                if (accept) begin
                    state_nxt  = ST_RUN;
                    first_nxt  = 1'b1;
                    op_nxt     = insn_op_i;
                    reg_nxt    = insn_reg_i;
                    sel_nxt    = insn_ptr_i;
                    imm_nxt    = insn_imm_i;
                    cnt_nxt    = cycles_of(insn_op_i);
                    wb_low_nxt = (insn_op_i == OP_CODE_READ_LOW);
                    if (cycles_of(insn_op_i) == CYC_CTRL) begin
                        done_nxt  = 1'b1;
                        sleep_nxt = (insn_op_i == OP_SLEEP);
                        wdt_nxt   = (insn_op_i == OP_WATCHDOG_RESTART);
                        brk_nxt   = (insn_op_i == OP_BREAK);
                    end
                end
            end
            ST_RUN: begin
                if (first_r) begin
                    case (op_r)
                        OP_LOAD_DIRECT: begin
                            daddr_nxt = imm_r;
                            dre_nxt   = 1'b1;
                        end
                        OP_STORE_DIRECT: begin
                            daddr_nxt = imm_r;
                            wdata_nxt = rf.rd_data;
                            dwe_nxt   = 1'b1;
                        end
                        OP_PTR_WRITE, OP_PTR_WRITE_INC: begin
                            daddr_nxt = ptr_cur;
                            wdata_nxt = rf.rd_data;
                            dwe_nxt   = 1'b1;
                            ptr_new   = AW'(ptr_cur + PTR_STEP);
                            ptr_upd   = (op_r == OP_PTR_WRITE_INC);
                        end
                        OP_PTR_WRITE_DEC: begin
                            ptr_new   = AW'(ptr_cur - PTR_STEP);
                            ptr_upd   = 1'b1;
                            daddr_nxt = ptr_new;
                            wdata_nxt = rf.rd_data;
                            dwe_nxt   = 1'b1;
                        end
                        OP_OFFSET_WRITE: begin
                            daddr_nxt = AW'(ptr_cur + imm_r);
                            wdata_nxt = rf.rd_data;
                            dwe_nxt   = 1'b1;
                        end
                        OP_CODE_READ_LOW, OP_CODE_READ, OP_CODE_READ_INC: begin
                            paddr_nxt = pz_r;
                            pre_nxt   = 1'b1;
                            pz_nxt    = (op_r == OP_CODE_READ_INC) ?
                                        AW'(pz_r + PTR_STEP) : pz_r;
                        end
                        OP_POP: begin
                            sp_nxt    = AW'(sp_r + PTR_STEP);
                            daddr_nxt = AW'(sp_r + PTR_STEP);
                            dre_nxt   = 1'b1;
                        end
                        default: ;
                    endcase
                end
                if (ptr_upd) case (sel_r)
                    PTR_FIRST: px_nxt = ptr_new;
                    PTR_THIRD: pz_nxt = ptr_new;
                    default:   py_nxt = ptr_new;
                endcase
                cnt_nxt = cnt_r - 2'h1;
                if (cnt_r == 2'h2) done_nxt = 1'b1;
                if (cnt_r == 2'h1) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        ready_nxt = (state_nxt == ST_IDLE);
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 2'h0;
            first_r  <= 1'b0;
            op_r     <= OP_NOP;
            reg_r    <= 5'h00;
            sel_r    <= PTR_FIRST;
            imm_r    <= 16'h0000;
            px_r     <= PTR_RESET;
            py_r     <= PTR_RESET;
            pz_r     <= PTR_RESET;
            sp_r     <= SP_RESET;
            daddr_r  <= 16'h0000;
            wdata_r  <= 8'h00;
            dwe_r    <= 1'b0;
            dre_r    <= 1'b0;
            paddr_r  <= 16'h0000;
            pre_r    <= 1'b0;
            ready_r  <= 1'b1;
            done_r   <= 1'b0;
            sleep_r  <= 1'b0;
            wdt_r    <= 1'b0;
            brk_r    <= 1'b0;
            wb_low_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            first_r  <= first_nxt;
            op_r     <= op_nxt;
            reg_r    <= reg_nxt;
            sel_r    <= sel_nxt;
            imm_r    <= imm_nxt;
            px_r     <= px_nxt;
            py_r     <= py_nxt;
            pz_r     <= pz_nxt;
            sp_r     <= sp_nxt;
            daddr_r  <= daddr_nxt;
            wdata_r  <= wdata_nxt;
            dwe_r    <= dwe_nxt;
            dre_r    <= dre_nxt;
            paddr_r  <= paddr_nxt;
            pre_r    <= pre_nxt;
            ready_r  <= ready_nxt;
            done_r   <= done_nxt;
            sleep_r  <= sleep_nxt;
            wdt_r    <= wdt_nxt;
            brk_r    <= brk_nxt;
            wb_low_r <= wb_low_nxt;
        end
    end
    assign ready_o            = ready_r;
    assign done_o             = done_r;
    assign dmem_addr_o        = daddr_r;
    assign dmem_wdata_o       = wdata_r;
    assign dmem_we_o          = dwe_r;
    assign dmem_re_o          = dre_r;
    assign pmem_addr_o        = paddr_r;
    assign pmem_re_o          = pre_r;
    assign sleep_o            = sleep_r;
    assign watchdog_restart_o = wdt_r;
    assign break_o            = brk_r;
    assign dbg_reg_data_o     = rf.dbg_data;
    assign ptr_first_o        = px_r;
    assign ptr_second_o       = py_r;
    assign ptr_third_o        = pz_r;
    assign sp_o               = sp_r;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    load_direct_a: assert property (accept && insn_op_i == OP_LOAD_DIRECT |-> ##2
        (dmem_re_o && done_o && dmem_addr_o == $past(insn_imm_i, 2)) ##1 ready_o)
        else $error("direct load timing or address wrong");
    store_direct_a: assert property (accept && insn_op_i == OP_STORE_DIRECT |=>
        !ready_o ##1 (dmem_we_o && done_o && dmem_addr_o == $past(insn_imm_i, 2)) ##1 ready_o)
        else $error("direct store timing or address wrong");
    post_inc_a: assert property (accept && insn_op_i == OP_PTR_WRITE_INC
        && insn_ptr_i == PTR_THIRD |-> ##2 (dmem_we_o && dmem_addr_o == $past(ptr_third_o, 2)
        && ptr_third_o == AW'($past(ptr_third_o, 2) + PTR_STEP)))
        else $error("post-increment store wrong");
    pre_dec_a: assert property (accept && insn_op_i == OP_PTR_WRITE_DEC
        && insn_ptr_i == PTR_FIRST |-> ##2 (dmem_we_o
        && ptr_first_o == AW'($past(ptr_first_o, 2) - PTR_STEP) && dmem_addr_o == ptr_first_o))
        else $error("pre-decrement store wrong");
    offset_store_a: assert property (accept && insn_op_i == OP_OFFSET_WRITE
        && insn_ptr_i == PTR_SECOND |-> ##2 (dmem_we_o && $stable(ptr_second_o)
        && dmem_addr_o == AW'($past(ptr_second_o, 2) + $past(insn_imm_i, 2))))
        else $error("offset store wrong");
    code_read_a: assert property (accept && insn_op_i == OP_CODE_READ_INC |->
        ##2 (pmem_re_o && pmem_addr_o == $past(ptr_third_o, 2)) ##1 (done_o && !ready_o)
        ##1 ready_o)
        else $error("code read timing wrong");
    pop_stack_a: assert property (accept && insn_op_i == OP_POP |-> ##2
        (dmem_re_o && dmem_addr_o == AW'($past(sp_o, 2) + PTR_STEP) && dmem_addr_o == sp_o))
        else $error("pop address wrong");
    sleep_cycle_a: assert property (accept && insn_op_i == OP_SLEEP |=>
        sleep_o && done_o ##1 ready_o && !sleep_o) else $error("sleep not one cycle");
    wdt_cycle_a: assert property (watchdog_restart_o |->
        $past(accept) && $past(insn_op_i) == OP_WATCHDOG_RESTART && done_o)
        else $error("watchdog restart without request");
    break_pulse_a: assert property (accept && insn_op_i == OP_BREAK |=> break_o
        && !dmem_we_o && !dmem_re_o) else $error("break effect wrong");
    ptr_wrap_a: assert property (accept && insn_op_i == OP_PTR_WRITE_INC
        && insn_ptr_i == PTR_SECOND && ptr_second_o == 16'hFFFF |-> ##2 ptr_second_o == 16'h0000)
        else $error("pointer did not wrap");
    cov_load_c:  cover property (accept && insn_op_i == OP_LOAD_DIRECT ##3 ready_o);
    cov_code_c:  cover property (accept && insn_op_i == OP_CODE_READ_LOW ##4 ready_o);
    cov_pop_c:   cover property (accept && insn_op_i == OP_POP ##2 dmem_re_o);
    cov_b2b_c:   cover property (done_o ##1 accept);
endmodule : load_store_exec
`default_nettype wire

// ==== dv/mem_model.sv ====
// data and program memory model facing the execution block
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input  wire logic        mclk_i,
    input  wire logic [15:0] dmem_addr_i,
    input  wire logic [7:0]  dmem_wdata_i,
    input  wire logic        dmem_we_i,
    input  wire logic        dmem_re_i,
    output logic [7:0]       dmem_rdata_o,
    input  wire logic [15:0] pmem_addr_i,
    input  wire logic        pmem_re_i,
    output logic [7:0]       pmem_rdata_o
);
    logic [7:0] mem_r [256];
    logic       tog_r = 1'b0;
    // idle read lines toggle, so a sample outside the strobe cannot match by luck
    always @(posedge mclk_i) begin
        tog_r <= ~tog_r;
        if (dmem_we_i) begin
            mem_r[dmem_addr_i[7:0]] <= dmem_wdata_i;
        end
    end
    assign dmem_rdata_o = dmem_re_i ? mem_r[dmem_addr_i[7:0]] : {8{tog_r}};
    assign pmem_rdata_o = pmem_re_i ? (pmem_addr_i[7:0] ^ pmem_addr_i[15:8] ^ 8'h5A) : {8{~tog_r}};
endmodule : mem_model
`default_nettype wire

// ==== dv/load_store_insn_subset_bench.sv ====
// self-checking bench for the load/store execution block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module load_store_insn_subset_bench
    import exec_pkg::*;
;
    logic        mclk_i = 1'b0, rstn_i = 1'b0, insn_valid_i = 1'b0;
    op_type      insn_op_i = OP_NOP;
    ptr_type     insn_ptr_i = PTR_FIRST, ptr_load_sel_i = PTR_FIRST;
    logic [4:0]  insn_reg_i = 5'h00, rf_load_addr_i = 5'h00, dbg_reg_addr_i = 5'h00;
    logic [15:0] insn_imm_i = 16'h0000, ptr_load_data_i = 16'h0000, sp_load_data_i = 16'h0000;
    logic        ptr_load_i = 1'b0, sp_load_i = 1'b0, rf_load_i = 1'b0;
    logic [7:0]  rf_load_data_i = 8'h00, dmem_rdata_i, pmem_rdata_i, dmem_wdata_o, dbg_reg_data_o;
    logic        ready_o, done_o, dmem_we_o, dmem_re_o, pmem_re_o;
    logic        sleep_o, watchdog_restart_o, break_o;
    logic [15:0] dmem_addr_o, pmem_addr_o, ptr_first_o, ptr_second_o, ptr_third_o, sp_o;
    logic [15:0] wa, pa;
    logic [7:0]  wd, rb;
    logic [2:0]  pm;
    int          lo, dn, wen, n_mismatch = 0, n_checks = 0, cyc = 0;

    load_store_exec i_dut (.mclk_i, .rstn_i, .insn_valid_i, .insn_op_i, .insn_reg_i,
        .insn_ptr_i, .insn_imm_i, .ready_o, .done_o, .dmem_addr_o, .dmem_wdata_o, .dmem_we_o,
        .dmem_re_o, .dmem_rdata_i, .pmem_addr_o, .pmem_re_o, .pmem_rdata_i, .sleep_o,
        .watchdog_restart_o, .break_o, .ptr_load_i, .ptr_load_sel_i, .ptr_load_data_i,
        .sp_load_i, .sp_load_data_i, .rf_load_i, .rf_load_addr_i, .rf_load_data_i,
        .dbg_reg_addr_i, .dbg_reg_data_o, .ptr_first_o, .ptr_second_o, .ptr_third_o, .sp_o);
    mem_model i_mem (.mclk_i(mclk_i), .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o),
        .dmem_we_i(dmem_we_o), .dmem_re_i(dmem_re_o), .dmem_rdata_o(dmem_rdata_i),
        .pmem_addr_i(pmem_addr_o), .pmem_re_i(pmem_re_o), .pmem_rdata_o(pmem_rdata_i));

    initial forever #20 mclk_i = ~mclk_i;

    function automatic logic [15:0] pv(input ptr_type p);
        return (p == PTR_FIRST) ? ptr_first_o : (p == PTR_SECOND) ? ptr_second_o : ptr_third_o;
    endfunction : pv

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // preload only between instructions; the block ignores it while busy
    task automatic ld(input ptr_type p, input logic [15:0] v, input logic [4:0] r,
                      input logic [7:0] d);
        ptr_load_i <= 1'b1;
        ptr_load_sel_i <= p;
        ptr_load_data_i <= v;
        sp_load_i <= 1'b1;
        sp_load_data_i <= v;
        rf_load_i <= 1'b1;
        rf_load_addr_i <= r;
        rf_load_data_i <= d;
        @(posedge mclk_i);
        ptr_load_i <= 1'b0;
        sp_load_i <= 1'b0;
        rf_load_i <= 1'b0;
    endtask : ld

    task automatic peek(input logic [4:0] r);
        dbg_reg_addr_i <= r;
        @(posedge mclk_i);
        @(negedge mclk_i);
        rb = dbg_reg_data_o;
        @(posedge mclk_i);
    endtask : peek

    task automatic run(input op_type o, input logic [4:0] r, input ptr_type p,
                       input logic [15:0] k, input int n);
        insn_valid_i <= 1'b1;
        insn_op_i <= o;
        insn_reg_i <= r;
        insn_ptr_i <= p;
        insn_imm_i <= k;
        @(posedge mclk_i);
        insn_valid_i <= 1'b0;
        lo = 0;
        dn = 0;
        wen = 0;
        pm = 3'h0;
        for (int i = 1; i <= n + 1; i++) begin
            @(negedge mclk_i);
            if (ready_o !== 1'b1) lo++;
            if (done_o === 1'b1) dn = i;
            if (dmem_we_o === 1'b1) begin
                wen++;
                wa = dmem_addr_o;
                wd = dmem_wdata_o;
            end
            if (pmem_re_o === 1'b1) pa = pmem_addr_o;
            pm = pm | {sleep_o, watchdog_restart_o, break_o};
            @(posedge mclk_i);
        end
        `CHK("busy", lo, n)
        `CHK("done", dn, n)
    endtask : run

    task automatic t_direct;
        ld(PTR_FIRST, 16'h0000, 5'h05, 8'hA5);
        run(OP_STORE_DIRECT, 5'h05, PTR_FIRST, 16'h0123, 2);
        `CHK("sd write", {wen[3:0], pm, wd, wa}, {4'h1, 3'h0, 8'hA5, 16'h0123})
        run(OP_LOAD_DIRECT, 5'h07, PTR_FIRST, 16'h0123, 2);
        peek(5'h07);
        `CHK("ld reg", rb, 8'hA5)
        $display("test direct done");
    endtask : t_direct

    task automatic t_ptr;
        ptr_type p;
        for (int i = 0; i < 3; i++) begin
            p = ptr_type'(i);
            ld(p, 16'hFFFF, 5'h04, 8'h11);
            run(OP_PTR_WRITE, 5'h04, p, 16'h0000, 2);
            `CHK("plain", {wen[3:0], wd, wa, pv(p)}, {4'h1, 8'h11, 32'hFFFFFFFF})
            run(OP_PTR_WRITE_INC, 5'h04, p, 16'h0000, 2);
            `CHK("inc", {wa, pv(p)}, {16'hFFFF, 16'h0000})
            run(OP_PTR_WRITE_DEC, 5'h04, p, 16'h0000, 2);
            `CHK("dec", {wd, wa, pv(p)}, {8'h11, 16'hFFFF, 16'hFFFF})
        end
        $display("test pointer done");
    endtask : t_ptr

    task automatic t_offset;
        ptr_type p;
        for (int i = 1; i < 3; i++) begin
            p = ptr_type'(i);
            ld(p, 16'h1000, 5'h06, 8'h66);
            run(OP_OFFSET_WRITE, 5'h06, p, 16'h0034, 2);
            `CHK("offset", {wd, wa, pv(p)}, {8'h66, 16'h1034, 16'h1000})
        end
        $display("test offset done");
    endtask : t_offset

    task automatic t_code;
        ld(PTR_THIRD, 16'h00FF, 5'h01, 8'h00);
        run(OP_CODE_READ_LOW, 5'h09, PTR_THIRD, 16'h0000, 3);
        peek(5'h00);
        `CHK("low", {pa, rb}, {16'h00FF, 8'hA5})
        ld(PTR_THIRD, 16'hFFFF, 5'h01, 8'h00);
        run(OP_CODE_READ_INC, 5'h09, PTR_THIRD, 16'h0000, 3);
        peek(5'h09);
        `CHK("inc", {rb, ptr_third_o}, {8'h5A, 16'h0000})
        run(OP_CODE_READ, 5'h0A, PTR_THIRD, 16'h0000, 3);
        peek(5'h0A);
        `CHK("plain", {rb, ptr_third_o}, {8'h5A, 16'h0000})
        $display("test code read done");
    endtask : t_code

    task automatic t_pop;
        ld(PTR_FIRST, 16'h00FF, 5'h02, 8'h3C);
        run(OP_STORE_DIRECT, 5'h02, PTR_FIRST, 16'h0100, 2);
        run(OP_POP, 5'h03, PTR_FIRST, 16'h0000, 2);
        peek(5'h03);
        `CHK("pop", {rb, sp_o}, {8'h3C, 16'h0100})
        $display("test pop done");
    endtask : t_pop

    task automatic t_ctrl;
        op_type ops [3] = '{OP_SLEEP, OP_WATCHDOG_RESTART, OP_BREAK};
        for (int i = 0; i < 3; i++) begin
            run(ops[i], 5'h00, PTR_FIRST, 16'h0000, 1);
            `CHK("pulse", pm, 3'b100 >> i)
        end
        $display("test control done");
    endtask : t_ctrl

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        t_direct();
        t_ptr();
        t_offset();
        t_code();
        t_pop();
        t_ctrl();
        tally_and_finish();
    end
endmodule : load_store_insn_subset_bench
`default_nettype wire
